// File: rtl/dwr_regs.vh
// Constants for the processor wake and result-interrupt wrapper.
// Assumes inclusion by bare name; definitions only.
`ifndef DWR_REGS_VH
`define DWR_REGS_VH
`define DWR_DATA_W 48
`define DWR_RAM_DEPTH 48
`define DWR_RAM_AW 6
`define DWR_RES_AW 4
`define DWR_NUM_RES 15
`define DWR_RES_W 24
`define DWR_OP_W 4
`define DWR_OP_NOP 4'h0
`define DWR_OP_LDI 4'h1
`define DWR_OP_LDM 4'h2
`define DWR_OP_STM 4'h3
`define DWR_OP_ADD 4'h4
`define DWR_OP_SUB 4'h5
`define DWR_OP_WRES 4'h6
`define DWR_OP_LIN 4'h7
`define DWR_OP_RDY 4'h8
`define DWR_OP_STOP 4'h9
`define DWR_OP_JMP 4'ha
`define DWR_PC_W 8
`define DWR_PC_RST 8'h00
`define DWR_CORE_MHZ 25
`define DWR_PROC_MHZ 100
`define DWR_INSN_W 32
`define DWR_FRAC_LSB 21
`endif

// File: rtl/dwr_clk_gate.v
// Processor clock gate: a run enable pulse stream derived from the core clock.
// Assumes one core clock; the stopped processor sees no enable pulses at all.
`timescale 1ns/1ps
`include "dwr_regs.vh"
module dwr_clk_gate (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire stop_req_i,
   input wire wake_req_i,
   output reg running_o,
   output reg proc_en_o
);
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         running_o <= 1'b1;
         proc_en_o <= 1'b0;
      end else begin
         if (running_o && stop_req_i) begin
            running_o <= 1'b0;
         end else if (!running_o && wake_req_i) begin
            running_o <= 1'b1;
         end
         proc_en_o <= running_o && !(stop_req_i && running_o);
      end
   end
endmodule

// File: rtl/dwr_top.v
// Wrapper around the embedded signal processor: gated clock, wake logic,
// 48x48 working RAM, result registers and the data-ready interrupt pins.
// Assumes firmware arrives as instruction words on a synchronous fetch port.
`timescale 1ns/1ps
`include "dwr_regs.vh"
module dwr_top (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [`DWR_INSN_W-1:0] insn_i,
   input wire gpio_wake_i,
   input wire run_end_i,
   input wire [`DWR_RES_AW-1:0] res_sel_i,
   input wire res_rd_i,
   output reg [`DWR_PC_W-1:0] pc_o,
   output reg [`DWR_RES_W-1:0] res_data_o,
   output reg [`DWR_RES_W-1:0] pulse_code_o,
   output reg data_ready_irq_pin_n_o,
   output reg alt_irq_gpio_pin_n_o,
   output reg alt_irq_gpio_pin_oe_o,
   output reg proc_running_o
);
   localparam [3:0] ST_FETCH = 4'b0001;
   localparam [3:0] ST_EXEC = 4'b0010;
   localparam [3:0] ST_HALT = 4'b0100;
   localparam [3:0] ST_WAKE = 4'b1000;

   reg [3:0] state_q;
   reg [`DWR_DATA_W-1:0] acc_q;
   reg [`DWR_DATA_W-1:0] ram_q [0:`DWR_RAM_DEPTH-1];
   reg [`DWR_RES_W-1:0] res_q [0:`DWR_NUM_RES-1];
   reg [`DWR_INSN_W-1:0] insn_q;
   reg stop_q;
   wire running;
   wire proc_en;
   wire wake_req;
   wire [`DWR_OP_W-1:0] op;
   wire [`DWR_RAM_AW-1:0] ram_a;
   wire [`DWR_RES_AW-1:0] res_a;
   wire [`DWR_DATA_W-1:0] ram_rd;
   integer i;
   // Depth held at the index width so the wrap subtraction stays in range
   localparam [`DWR_RAM_AW-1:0] RAM_DEPTH_A = `DWR_RAM_DEPTH;

   // Wrap RAM index (subtract 48) so a stray address never reaches past the 48 words
   function [`DWR_RAM_AW-1:0] ram_idx;
      input [`DWR_RAM_AW-1:0] a;
      begin
         if (a >= RAM_DEPTH_A)
            ram_idx = a - RAM_DEPTH_A;
         else
            ram_idx = a;
      end
   endfunction

   // Unsigned 3.21 ratio taken from the accumulator, saturating at max
   function [`DWR_RES_W-1:0] to_ratio;
      input [`DWR_DATA_W-1:0] v;
      begin
         if (|v[`DWR_DATA_W-1:`DWR_RES_W])
            to_ratio = {`DWR_RES_W{1'b1}};
         else
            to_ratio = v[`DWR_RES_W-1:0];
      end
   endfunction

   assign op = insn_q[`DWR_INSN_W-1:`DWR_INSN_W-`DWR_OP_W];
   assign ram_a = ram_idx(insn_q[`DWR_RAM_AW-1:0]);
   assign res_a = insn_q[`DWR_RES_AW-1:0];
   assign ram_rd = ram_q[ram_a];
   assign wake_req = (gpio_wake_i | run_end_i) & ~running;

   dwr_clk_gate u_gate (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .stop_req_i(stop_q),
      .wake_req_i(wake_req),
      .running_o(running),
      .proc_en_o(proc_en)
   );

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_FETCH;
         pc_o <= `DWR_PC_RST;
         insn_q <= {`DWR_INSN_W{1'b0}};
         acc_q <= {`DWR_DATA_W{1'b0}};
         stop_q <= 1'b0;
         pulse_code_o <= {`DWR_RES_W{1'b0}};
         data_ready_irq_pin_n_o <= 1'b1;
         alt_irq_gpio_pin_n_o <= 1'b1;
         alt_irq_gpio_pin_oe_o <= 1'b0;
         res_data_o <= {`DWR_RES_W{1'b0}};
         proc_running_o <= 1'b1;
         for (i = 0; i < `DWR_RAM_DEPTH; i = i + 1)
            ram_q[i] <= {`DWR_DATA_W{1'b0}};
         for (i = 0; i < `DWR_NUM_RES; i = i + 1)
            res_q[i] <= {`DWR_RES_W{1'b0}};
      end else begin
         proc_running_o <= running;
         stop_q <= 1'b0;
         alt_irq_gpio_pin_oe_o <= 1'b1;
         if (res_rd_i) begin
            if (res_sel_i < `DWR_NUM_RES)
               res_data_o <= res_q[res_sel_i];
            else
               res_data_o <= {`DWR_RES_W{1'b0}};
         end
         case (state_q)
            ST_FETCH: begin
               if (proc_en) begin
                  insn_q <= insn_i;
                  pc_o <= pc_o + 1'b1;
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (proc_en) begin
                  state_q <= ST_FETCH;
                  if (op == `DWR_OP_LDI) begin
                     acc_q <= {{(`DWR_DATA_W-`DWR_INSN_W+`DWR_OP_W){1'b0}}, insn_q[`DWR_INSN_W-`DWR_OP_W-1:0]};
                  end else if (op == `DWR_OP_LDM) begin
                     acc_q <= ram_rd;
                  end else if (op == `DWR_OP_STM) begin
                     ram_q[ram_a] <= acc_q;
                  end else if (op == `DWR_OP_ADD) begin
                     acc_q <= acc_q + ram_rd;
                  end else if (op == `DWR_OP_SUB) begin
                     acc_q <= acc_q - ram_rd;
                  end else if (op == `DWR_OP_WRES) begin
                     if (res_a < `DWR_NUM_RES)
                        res_q[res_a] <= to_ratio(acc_q);
                  end else if (op == `DWR_OP_LIN) begin
                     pulse_code_o <= to_ratio(((acc_q * ram_rd) >> `DWR_FRAC_LSB) + ram_q[ram_idx(ram_a + 1'b1)]);
                  end else if (op == `DWR_OP_RDY) begin
                     data_ready_irq_pin_n_o <= 1'b0;
                     alt_irq_gpio_pin_n_o <= 1'b0;
                  end else if (op == `DWR_OP_STOP) begin
                     stop_q <= 1'b1;
                     state_q <= ST_HALT;
                  end else if (op == `DWR_OP_JMP) begin
                     pc_o <= insn_q[`DWR_PC_W-1:0];
                  end
               end
            end
            ST_HALT: begin
               if (wake_req)
                  state_q <= ST_WAKE;
            end
            ST_WAKE: begin
               if (running)
                  state_q <= ST_FETCH;
            end
            default: begin
               state_q <= ST_FETCH;
            end
         endcase
         // Host read of results releases the interrupt; a new ready wins
         if (res_rd_i && !(state_q == ST_EXEC && proc_en && op == `DWR_OP_RDY)) begin
            data_ready_irq_pin_n_o <= 1'b1;
            alt_irq_gpio_pin_n_o <= 1'b1;
         end
      end
   end
endmodule

// File: verif/dwr_host_model.sv
// Host model: waits for data ready, then reads result registers.
// Assumes the wrapper's core clock; one strobe cycle per read.
`timescale 1ns/1ps
module dwr_host_model (
   input wire core_clk_i,
   input wire irq_n_i,
   input wire alt_irq_n_i,
   input wire [23:0] res_data_i,
   output reg [3:0] res_sel_o = 4'h0,
   output reg res_rd_o = 1'b0
);
   task wait_irq(output ok);
      integer i;
      begin
         ok = 1'b0;
         for (i = 0; i < 60 && !ok; i = i + 1) begin
            @(negedge core_clk_i);
            ok = !irq_n_i || !alt_irq_n_i;
         end
      end
   endtask
   // interrupt driven, so no duplicate filter is needed
   task rd(input [3:0] s, output [23:0] d);
      begin
         @(posedge core_clk_i);
         res_sel_o <= s;
         res_rd_o <= 1'b1;
         @(posedge core_clk_i);
         res_rd_o <= 1'b0;
         res_sel_o <= ~s;
         @(negedge core_clk_i);
         d = res_data_i;
      end
   endtask
endmodule

// File: verif/dwr_chk.sv
// Port checker for the wake and result-interrupt wrapper.
// Assumes one core clock; bound to the top module below.
`timescale 1ns/1ps
module dwr_chk (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire gpio_wake_i,
   input wire run_end_i,
   input wire [3:0] res_sel_i,
   input wire res_rd_i,
   input wire [7:0] pc_o,
   input wire [23:0] res_data_o,
   input wire data_ready_irq_pin_n_o,
   input wire alt_irq_gpio_pin_n_o,
   input wire alt_irq_gpio_pin_oe_o,
   input wire proc_running_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence wake_ev;
      !proc_running_o && (gpio_wake_i || run_end_i);
   endsequence
   sequence restart;
      ##[1:3] proc_running_o;
   endsequence
   a_stop_freezes_pc: assert property (!proc_running_o |=> $stable(pc_o))
      else $error("pc moved while stopped");
   a_wake_restarts: assert property (wake_ev |-> restart)
      else $error("no restart after wake");
   a_wake_has_cause: assert property ($rose(proc_running_o) |-> $past(gpio_wake_i, 2) || $past(run_end_i, 2))
      else $error("restart without wake");
   a_pins_agree: assert property (data_ready_irq_pin_n_o == alt_irq_gpio_pin_n_o)
      else $error("irq pins differ");
   a_pin_driven: assert property ($past(rst_n_i) |-> alt_irq_gpio_pin_oe_o)
      else $error("gpio irq pin not driven");
   a_irq_holds: assert property (!data_ready_irq_pin_n_o && !res_rd_i |=> !data_ready_irq_pin_n_o)
      else $error("irq dropped without read");
   a_bad_sel_zero: assert property (res_rd_i && res_sel_i > 4'he |=> res_data_o == 24'h000000)
      else $error("unmapped result not zero");
   a_data_stands: assert property (!res_rd_i |=> $stable(res_data_o))
      else $error("result changed without read");
endmodule
bind dwr_top dwr_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .gpio_wake_i(gpio_wake_i),
   .run_end_i(run_end_i), .res_sel_i(res_sel_i), .res_rd_i(res_rd_i), .pc_o(pc_o), .res_data_o(res_data_o),
   .data_ready_irq_pin_n_o(data_ready_irq_pin_n_o), .alt_irq_gpio_pin_n_o(alt_irq_gpio_pin_n_o),
   .alt_irq_gpio_pin_oe_o(alt_irq_gpio_pin_oe_o), .proc_running_o(proc_running_o));

// File: verif/tb_top.sv
// Bench for the wrapper: program table as firmware, host model reads.
// Assumes 25 MHz core clock and a low active reset.
`timescale 1ns/1ps
module tb_top;
   reg core_clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg gpio_wake_i = 1'b0;
   reg run_end_i = 1'b0;
   wire [3:0] sel;
   wire rd;
   wire [7:0] pc;
   wire [23:0] data;
   wire [23:0] pcode;
   wire irq_n, alt_n, oe, run;
   reg [31:0] rom [0:7];
   reg [23:0] d;
   reg [7:0] pc0;
   reg ok;
   integer bad_count = 0;
   integer n_compared = 0;
   always #20 core_clk_i = ~core_clk_i;
   dwr_top uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .insn_i(rom[pc[2:0]]), .gpio_wake_i(gpio_wake_i),
      .run_end_i(run_end_i), .res_sel_i(sel), .res_rd_i(rd), .pc_o(pc), .res_data_o(data), .pulse_code_o(pcode),
      .data_ready_irq_pin_n_o(irq_n), .alt_irq_gpio_pin_n_o(alt_n), .alt_irq_gpio_pin_oe_o(oe),
      .proc_running_o(run));
   dwr_host_model host (.core_clk_i(core_clk_i), .irq_n_i(irq_n), .alt_irq_n_i(alt_n), .res_data_i(data),
      .res_sel_o(sel), .res_rd_o(rd));
   task check(input [8*16-1:0] name, input [23:0] seen, input [23:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %0s expected %h seen %h", name, exp, seen);
         end
      end
   endtask
   task wait_run(input v);
      integer i;
      begin
         for (i = 0; i < 30 && run !== v; i = i + 1) @(negedge core_clk_i);
         check("proc_running", run, v);
      end
   endtask
   task wake(input g);
      begin
         @(posedge core_clk_i);
         gpio_wake_i <= g;
         run_end_i <= !g;
         @(posedge core_clk_i);
         gpio_wake_i <= 1'b0;
         run_end_i <= 1'b0;
         repeat (3) @(negedge core_clk_i);
         check("proc_running", run, 1'b1);
      end
   endtask
   task t_first_result;
      begin
         host.wait_irq(ok);
         check("alt_irq_oe_seen", {alt_n, oe, ok}, 3'b011);
         host.rd(4'h3, d);
         check("result3", d, 24'h000005);
         check("irq_n", irq_n, 1'b1);
      end
   endtask
   task t_stop_gpio;
      begin
         wait_run(1'b0);
         pc0 = pc;
         repeat (6) @(negedge core_clk_i);
         check("pc_frozen", pc, pc0);
         wake(1'b1);
         repeat (4) @(negedge core_clk_i);
         check("pc_moved", pc !== pc0, 1'b1);
      end
   endtask
   task t_refused_then_run_end;
      begin
         host.wait_irq(ok);
         host.rd(4'hf, d);
         check("result15", d, 24'h000000);
         host.rd(4'h3, d);
         check("result3", d, 24'h000005);
         wait_run(1'b0);
         wake(1'b0);
         check("pulse_code", pcode, 24'h000000);
      end
   endtask
   task tally_and_finish;
      begin
         if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   initial begin
      rom[0] = 32'h10000005; rom[1] = 32'h60000003; rom[2] = 32'h80000000; rom[3] = 32'h90000000;
      rom[4] = 32'h6000000f; rom[5] = 32'h80000000; rom[6] = 32'h90000000; rom[7] = 32'ha0000000;
      repeat (8) @(posedge core_clk_i);
      check("reset_state", {pc, irq_n, run}, 10'h003);
      rst_n_i <= 1'b1;
      t_first_result;
      t_stop_gpio;
      t_refused_then_run_end;
      tally_and_finish;
   end
   initial begin
      #100000;
      bad_count = bad_count + 1;
      tally_and_finish;
   end
endmodule
